// File: apr_pkg.sv
// Shared constants for the parallel register port host controller
package apr_pkg;

  // Bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Clock period in picoseconds (250 MHz)
  localparam int CLK_PS = 4000;

  // Pin timing in nanoseconds, as printed
  localparam int T_RC_NS  = 70;  // Read cycle time
  localparam int T_ACS_NS = 70;  // Chip select access time
  localparam int T_OHZ_NS = 25;  // Output disable to high Z
  localparam int T_WC_NS  = 70;  // Write cycle time
  localparam int T_AS_NS  = 0;   // Address setup to write start
  localparam int T_WP_NS  = 55;  // Write pulse width
  localparam int T_DW_NS  = 30;  // Data valid to end of write
  localparam int T_DH_NS  = 10;  // Data hold after write end
  localparam int T_WR_NS  = 15;  // Write recovery
  localparam int T_WZ_NS  = 25;  // Write enable to output high Z

  // Least times round up to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Cycle counts derived from the times above
  localparam int C_SETUP  = cyc_min(T_AS_NS);
  localparam int C_RD     = cyc_min(T_ACS_NS) + 2;  // Plus two for input sync
  localparam int C_RDHZ   = cyc_min(T_OHZ_NS);
  localparam int C_WZ     = cyc_min(T_WZ_NS);
  localparam int C_WP     = cyc_min(T_WP_NS);
  localparam int C_HOLD   = cyc_min(T_DH_NS) + cyc_min(T_WR_NS);
  localparam int C_RC_PAD = cyc_min(T_RC_NS);
  localparam int C_WC_PAD = cyc_min(T_WC_NS);
  localparam int C_DW     = cyc_min(T_DW_NS);

  localparam int CNT_W = 6;

  // Controller states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SETUP = 7'h02,
    ST_RDACC = 7'h04,
    ST_RDHZ  = 7'h08,
    ST_WZ    = 7'h10,
    ST_WPUL  = 7'h20,
    ST_HOLD  = 7'h40
  } apr_state_e;

endpackage

// File: apr_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for the data pins coming back from the device
module apr_sync
(
  input  wire logic                       clk,   // System clock
  input  wire logic                       rst,   // Async reset, active high
  input  wire logic [apr_pkg::DATA_W-1:0] d,     // Asynchronous pin levels
  output logic      [apr_pkg::DATA_W-1:0] q      // Synchronised levels
);

  typedef struct packed {
    logic [apr_pkg::DATA_W-1:0] s1;
    logic [apr_pkg::DATA_W-1:0] s2;
  } apr_sync_s;

  apr_sync_s st_r;
  apr_sync_s st_nxt;

  // First stage is read only by the second stage
  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Register both stages
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule

// File: apr_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Strobe stays high through every read
// - Address changes only while select or strobe high
// - No conflicting write data before device outputs off
// - Read address stable before select falls
module apr_host
(
  input  wire logic                       clk,          // System clock
  input  wire logic                       rst,          // Async reset, active high
  input  wire logic                       req_valid,    // Access request
  input  wire logic                       req_write,    // 1 write, 0 read
  input  wire logic [apr_pkg::ADDR_W-1:0] req_addr,     // Register address
  input  wire logic [apr_pkg::DATA_W-1:0] req_wdata,    // Write data
  output logic                            req_ready,    // Idle, request taken
  output logic                            rsp_valid,    // Access done pulse
  output logic      [apr_pkg::DATA_W-1:0] rsp_rdata,    // Read data
  output logic      [apr_pkg::ADDR_W-1:0] reg_addr_lines, // Address pins
  output logic                            cs_n,         // Chip select, low active
  output logic                            we_n,         // Write strobe, low active
  output logic                            oe_n,         // Output gate, low active
  input  wire logic [apr_pkg::DATA_W-1:0] data_lines_i, // Data pins in
  output logic      [apr_pkg::DATA_W-1:0] data_lines_o, // Data pins out
  output logic                            data_lines_oe // Data pin drive enable
);

  typedef struct packed {
    apr_pkg::apr_state_e        state;
    logic [apr_pkg::CNT_W-1:0]  cnt;
    logic                       wr;
    logic [apr_pkg::ADDR_W-1:0] addr;
    logic [apr_pkg::DATA_W-1:0] wdata;
    logic [apr_pkg::DATA_W-1:0] rdata;
    logic                       ready;
    logic                       done;
    logic                       cs_n;
    logic                       we_n;
    logic                       oe_n;
    logic                       doe;
  } apr_host_s;

  apr_host_s                  st_r;
  apr_host_s                  st_nxt;
  logic [apr_pkg::DATA_W-1:0] din_sync;

  // Data pins pass two flops before use
  apr_sync u_sync
  (
    .clk (clk),
    .rst (rst),
    .d   (data_lines_i),
    .q   (din_sync)
  );

  // Sequencer for read and write cycles
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (st_r.cnt != '0)
      st_nxt.cnt = st_r.cnt - 1'b1;
    unique case (st_r.state)
      apr_pkg::ST_IDLE:
      begin
        st_nxt.cs_n = 1'b1;
        st_nxt.we_n = 1'b1;
        st_nxt.oe_n = 1'b1;
        st_nxt.doe  = 1'b0;
        st_nxt.ready = (st_nxt.cnt == '0);  // Ready only after the cycle-time pad
        if (req_valid && st_r.ready && st_r.cnt == '0)
        begin
          // Address moves only while select is high
          st_nxt.addr  = req_addr;
          st_nxt.wr    = req_write;
          st_nxt.wdata = req_wdata;
          st_nxt.ready = 1'b0;
          st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_SETUP);
          st_nxt.state = apr_pkg::ST_SETUP;
        end
      end
      apr_pkg::ST_SETUP:
        if (st_r.cnt == '0)
        begin
          st_nxt.cs_n = 1'b0;
          if (st_r.wr)
          begin
            // Select falls first, strobe falls later to open the write
            st_nxt.oe_n  = 1'b1;
            st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_WZ);
            st_nxt.state = apr_pkg::ST_WZ;
          end
          else
          begin
            st_nxt.oe_n  = 1'b0;
            st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_RD);
            st_nxt.state = apr_pkg::ST_RDACC;
          end
        end
      apr_pkg::ST_RDACC:
        if (st_r.cnt == '0)
        begin
          st_nxt.rdata = din_sync;
          st_nxt.cs_n  = 1'b1;
          st_nxt.oe_n  = 1'b1;
          st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_RDHZ);
          st_nxt.state = apr_pkg::ST_RDHZ;
        end
      apr_pkg::ST_RDHZ:
        if (st_r.cnt == '0)
        begin
          st_nxt.done  = 1'b1;
          st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_RC_PAD);
          st_nxt.state = apr_pkg::ST_IDLE;
        end
      apr_pkg::ST_WZ:
        // Gate stays high, so pins are free before data is driven
        if (st_r.cnt == '0)
        begin
          st_nxt.we_n  = 1'b0;
          st_nxt.doe   = 1'b1;
          st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_WP);
          st_nxt.state = apr_pkg::ST_WPUL;
        end
      apr_pkg::ST_WPUL:
        // Data stands the whole pulse, well over the data setup
        if (st_r.cnt == '0)
        begin
          st_nxt.we_n  = 1'b1;
          st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_HOLD);
          st_nxt.state = apr_pkg::ST_HOLD;
        end
      apr_pkg::ST_HOLD:
        // Data held after strobe rises, then select released
        if (st_r.cnt == '0)
        begin
          st_nxt.cs_n  = 1'b1;
          st_nxt.doe   = 1'b0;
          st_nxt.done  = 1'b1;
          st_nxt.cnt   = apr_pkg::CNT_W'(apr_pkg::C_WC_PAD);
          st_nxt.state = apr_pkg::ST_IDLE;
        end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r       <= '0;
      st_r.state <= apr_pkg::ST_IDLE;
      st_r.cs_n  <= 1'b1;
      st_r.we_n  <= 1'b1;
      st_r.oe_n  <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from flops
  assign req_ready      = st_r.ready;
  assign rsp_valid      = st_r.done;
  assign rsp_rdata      = st_r.rdata;
  assign reg_addr_lines = st_r.addr;
  assign cs_n           = st_r.cs_n;
  assign we_n           = st_r.we_n;
  assign oe_n           = st_r.oe_n;
  assign data_lines_o   = st_r.wdata;
  assign data_lines_oe  = st_r.doe;

endmodule

// File: apr_host_sva.sv
`timescale 1ns/1ps
// Watches the host pins for the rules that bind the bus master
module apr_host_sva
(
  input wire logic                       clk,           // System clock
  input wire logic                       rst,           // Async reset
  input wire logic                       cs_n,          // Chip select
  input wire logic                       we_n,          // Write strobe
  input wire logic                       oe_n,          // Output gate
  input wire logic                       data_lines_oe, // Host drives data
  input wire logic [apr_pkg::ADDR_W-1:0] reg_addr_lines // Address pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Pin relations over each access
  a_rd_strobe_off: assert property (!oe_n |-> we_n)
    else $error("strobe low in read");
  a_addr_held_sel: assert property (!cs_n && $past(!cs_n) |-> $stable(reg_addr_lines))
    else $error("address moved while selected");
  a_no_data_clash: assert property (!oe_n |-> !data_lines_oe)
    else $error("host drives into device");
  a_we_after_sel: assert property ($fell(we_n) |-> !cs_n && $past(!cs_n))
    else $error("strobe fell without prior select");
  a_data_around_end: assert property ($rose(we_n) |-> $past(data_lines_oe, 8) ##0 data_lines_oe [*3])
    else $error("write data not around strobe end");
  a_read_window: assert property ($fell(oe_n) |-> (!oe_n && !cs_n && we_n) [*8])
    else $error("read window too short");
endmodule

// File: apr_dev_model.sv
`timescale 1ns/1ps
// Register device on the far side of the port, with fast or slow output
module apr_dev_model
(
  input  wire logic       cs_n, // Chip select
  input  wire logic       we_n, // Write strobe
  input  wire logic       oe_n, // Output gate
  input  wire logic [3:0] addr, // Register address
  input  wire logic [7:0] h_d,  // Host data
  input  wire logic       h_oe, // Host drives
  input  wire logic       slow, // Slow output
  output logic      [7:0] bus   // Resolved pins
);
  logic [7:0] mem [16];
  logic       rd_ok = 1'b0;
  logic       d_f;
  logic       d_s;
  // Select falling with strobe low never turns the outputs on
  always @(negedge cs_n) rd_ok = we_n;
  // Overlap ends at the first rising edge of select or strobe, data latched then
  always @(posedge cs_n or posedge we_n)
  begin
    if (cs_n ^ we_n) mem[addr] = h_d;
  end
  // Output drive only selected, gated and not writing
  assign #10 d_f = !cs_n && !oe_n && we_n && rd_ok;
  assign #60 d_s = !cs_n && !oe_n && we_n && rd_ok;
  // Undriven pins show the inverse so stale data never matches
  always @*
  begin
    if (h_oe) bus = h_d;
    else if (slow ? d_s : d_f) bus = mem[addr];
    else bus = ~mem[addr];
  end
endmodule

// File: test_async_parallel_register_port.sv
`timescale 1ns/1ps
// Runs writes and reads through the host controller into the device model
module test_async_parallel_register_port;
  logic       clk = 1'b0;
  logic       rst;
  logic       req_valid = 1'b0;
  logic       req_write = 1'b0;
  logic [3:0] req_addr = 4'h0;
  logic [7:0] req_wdata = 8'h00;
  logic       slow = 1'b0;
  logic       req_ready, rsp_valid, cs_n, we_n, oe_n, d_oe;
  logic [7:0] rsp_rdata, d_o, bus;
  logic [3:0] addr;
  int         err_count = 0;
  int         checks = 0;
  always #2 clk = ~clk;
  apr_host i_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .reg_addr_lines(addr), .cs_n(cs_n),
    .we_n(we_n), .oe_n(oe_n), .data_lines_i(bus), .data_lines_o(d_o), .data_lines_oe(d_oe));
  apr_dev_model i_dev (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .h_d(d_o),
    .h_oe(d_oe), .slow(slow), .bus(bus));
  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
      err_count++;
    end
  endtask
  // One access: wait ready, request for one edge, wait the done pulse
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1 n++;
    end
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    @(posedge clk);
    #1 req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 400)
    begin
      $display("unexpected t=%0t exp=%h got=%h", $time, 1'b1, rsp_valid);
      err_count++;
    end
    q = rsp_rdata;
  endtask
  function automatic logic [7:0] pat(input logic [3:0] a);
    return {~a, a} ^ 8'hA5;
  endfunction
  // Idle pin levels just after reset
  task automatic t_reset;
    chk(8'h0E, {4'h0, cs_n, we_n, oe_n, d_oe});
  endtask
  // Every address written, then read back
  task automatic t_fill_read;
    logic [7:0] q;
    for (int a = 0; a < 16; a++) acc(1'b1, 4'(a), pat(4'(a)), q);
    for (int a = 0; a < 16; a++)
    begin
      acc(1'b0, 4'(a), 8'h00, q);
      chk(pat(4'(a)), q);
    end
  endtask
  // Back-to-back write and read of one place with a slow device
  task automatic t_turnaround;
    logic [7:0] q;
    slow = 1'b1;
    acc(1'b1, 4'h5, 8'h3C, q);
    acc(1'b0, 4'h5, 8'h00, q);
    chk(8'h3C, q);
    acc(1'b1, 4'h5, 8'hC3, q);
    acc(1'b0, 4'h5, 8'h00, q);
    chk(8'hC3, q);
    acc(1'b0, 4'hA, 8'h00, q);
    chk(pat(4'hA), q);
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_reset;
    t_fill_read;
    t_turnaround;
    tally_and_finish;
  end
  initial
  begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule
bind apr_host apr_host_sva u_sva (.clk(clk), .rst(rst), .cs_n(cs_n), .we_n(we_n),
  .oe_n(oe_n), .data_lines_oe(data_lines_oe), .reg_addr_lines(reg_addr_lines));
